// ### hdl/smc_standby_ctrl.sv
// standby mode controller: standby entry on halt, nmi/watchdog-timed exit, reset exit
// assumes APB master on SYS_CLK; nmi and reset pins sampled synchronously to SYS_CLK
// Functional notes
// - halt with standby_select set enters standby
// - standby stops cpu, clock and peripherals
// - cpu registers and ram are held
// - ports hold or float per port_float_select
// - port_float_select 0 holds, 1 floats
// - entry initializes dma, timer pulse, adc
// - entry initializes all serial interface registers
// - entry clears watchdog bits 7-5 and reset reg
// - other controllers and control register held
// - exit only by nmi edge or reset
// - nmi edge restarts clock to watchdog only
// - watchdog overflow resumes clock, starts nmi handling
// - reset with nmi high gives power-on reset
// - reset with nmi low gives manual reset
// - edge select forced to falling in standby
// - standby_select refused while watchdog_enable set
`timescale 1ns/1ps

module smc_standby_ctrl (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic HALT_EXEC,
	input wire logic NMI_PIN,
	input wire logic RESET_PIN_N,
	output logic CPU_STOP,
	output logic SYS_CLK_STOP,
	output logic PERIPH_STOP,
	output logic WDOG_CLK_ONLY,
	output logic PORTS_FLOAT,
	output logic PORTS_HOLD,
	output logic DMA_INIT,
	output logic TPU_INIT,
	output logic ADC_INIT,
	output logic SERIAL_INIT,
	output logic NMI_EXCEPTION,
	output logic POWER_ON_RESET,
	output logic MANUAL_RESET,
	output logic NMI_EDGE_RISING
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	smc_pkg::smc_state_t state_r, state_nxt;
	logic [7:0] sby_ctrl_r, sby_ctrl_nxt;
	logic [7:0] wd_ctrl_r, wd_ctrl_nxt;
	logic [7:0] wd_rst_r, wd_rst_nxt;
	logic [7:0] wd_cnt_r, wd_cnt_nxt;
	logic [10:0] wd_pre_r, wd_pre_nxt;
	logic nmi_edge_sel_r, nmi_edge_sel_nxt;
	logic nmi_prev_r, nmi_prev_nxt;
	logic rst_prev_r, rst_prev_nxt;
	logic nmi_exc_r, nmi_exc_nxt;
	logic por_r, por_nxt;
	logic mrst_r, mrst_nxt;
	logic entry_r, entry_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [2:0] cks;
	logic tick;
	logic nmi_hit;
	logic rst_fall;
	logic wr;
	logic rd;
	smc_pkg::smc_power_t pwr;
	smc_pkg::smc_init_t init;

	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && !PENABLE && !PWRITE;
	assign cks = wd_ctrl_r[2:0];

	// ----------------------------------------
	// combinational next state
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		sby_ctrl_nxt = sby_ctrl_r;
		wd_ctrl_nxt = wd_ctrl_r;
		wd_rst_nxt = wd_rst_r;
		wd_cnt_nxt = wd_cnt_r;
		wd_pre_nxt = wd_pre_r;
		nmi_edge_sel_nxt = nmi_edge_sel_r;
		nmi_prev_nxt = NMI_PIN;
		rst_prev_nxt = RESET_PIN_N;
		nmi_exc_nxt = 1'b0;
		por_nxt = 1'b0;
		mrst_nxt = 1'b0;
		entry_nxt = 1'b0;
		prdata_nxt = prdata_r;
		tick = 1'b0;
		nmi_hit = 1'b0;
		rst_fall = rst_prev_r && !RESET_PIN_N;

		// register writes from software
		if (wr && state_r == smc_pkg::SMC_RUN) begin
			case (PADDR)
				smc_pkg::SMC_STANDBY_CTRL_ADDR: begin
					// standby and float bits refused while watchdog runs
					if (!wd_ctrl_r[smc_pkg::SMC_WDOG_EN_BIT]) begin
						sby_ctrl_nxt[smc_pkg::SMC_STANDBY_SELECT_BIT] =
							PWDATA[smc_pkg::SMC_STANDBY_SELECT_BIT];
						sby_ctrl_nxt[smc_pkg::SMC_PORT_FLOAT_BIT] =
							PWDATA[smc_pkg::SMC_PORT_FLOAT_BIT];
					end else begin
						sby_ctrl_nxt[smc_pkg::SMC_STANDBY_SELECT_BIT] = 1'b0 &
							PWDATA[smc_pkg::SMC_STANDBY_SELECT_BIT];
						sby_ctrl_nxt[smc_pkg::SMC_PORT_FLOAT_BIT] = 1'b0;
					end
				end
				smc_pkg::SMC_WDOG_CTRL_ADDR: wd_ctrl_nxt = PWDATA[7:0];
				smc_pkg::SMC_WDOG_RST_ADDR: wd_rst_nxt = PWDATA[7:0];
				smc_pkg::SMC_WDOG_CNT_ADDR: wd_cnt_nxt = PWDATA[7:0];
				smc_pkg::SMC_CPU_CTRL_ADDR:
					nmi_edge_sel_nxt = PWDATA[smc_pkg::SMC_NMI_EDGE_BIT];
				default: ;
			endcase
		end

		// watchdog counting while enabled or settling
		if (state_r == smc_pkg::SMC_SETTLE ||
			(state_r == smc_pkg::SMC_RUN && wd_ctrl_r[smc_pkg::SMC_WDOG_EN_BIT])) begin
			wd_pre_nxt = 11'(wd_pre_r + 11'h001);
			case (cks)
				3'h0: tick = wd_pre_r[0];
				3'h1: tick = &wd_pre_r[1:0];
				3'h2: tick = &wd_pre_r[4:0];
				3'h3: tick = &wd_pre_r[5:0];
				3'h4: tick = &wd_pre_r[6:0];
				3'h5: tick = &wd_pre_r[7:0];
				3'h6: tick = &wd_pre_r[8:0];
				default: tick = &wd_pre_r[10:0];
			endcase
			if (tick) begin
				wd_cnt_nxt = 8'(wd_cnt_r + 8'h01);
			end
		end

		// in standby the edge is always falling
		nmi_hit = nmi_edge_sel_r ? (!nmi_prev_r && NMI_PIN) : (nmi_prev_r && !NMI_PIN);
		if (state_r != smc_pkg::SMC_RUN) begin
			nmi_hit = nmi_prev_r && !NMI_PIN;
		end

		case (state_r)
			smc_pkg::SMC_RUN: begin
				if (HALT_EXEC && sby_ctrl_r[smc_pkg::SMC_STANDBY_SELECT_BIT]) begin
					state_nxt = smc_pkg::SMC_STANDBY;
					entry_nxt = 1'b1;
					// watchdog bits 7-5 and reset reg cleared, clock select and count kept
					wd_ctrl_nxt = {3'h0, wd_ctrl_r[4:0]} | smc_pkg::SMC_WDOG_CTRL_RST;
					wd_rst_nxt = smc_pkg::SMC_WDOG_RST_RST;
					wd_pre_nxt = 11'h000;
				end
			end
			smc_pkg::SMC_STANDBY: begin
				if (nmi_hit) begin
					state_nxt = smc_pkg::SMC_SETTLE;
				end
			end
			smc_pkg::SMC_SETTLE: begin
				if (tick && wd_cnt_r == 8'hFF) begin
					state_nxt = smc_pkg::SMC_RUN;
					nmi_exc_nxt = 1'b1;
					wd_ctrl_nxt[smc_pkg::SMC_WDOG_OVF_BIT] = 1'b1;
				end
			end
			default: state_nxt = smc_pkg::SMC_RUN;
		endcase

		// reset pin wins over the next state and the nmi exception, nmi level picks the kind
		if (rst_fall) begin
			state_nxt = smc_pkg::SMC_RUN;
			nmi_exc_nxt = 1'b0;
			por_nxt = NMI_PIN;
			mrst_nxt = !NMI_PIN;
			if (NMI_PIN) begin
				sby_ctrl_nxt = smc_pkg::SMC_STANDBY_CTRL_RST & 8'h1F;
				wd_ctrl_nxt = smc_pkg::SMC_WDOG_CTRL_RST;
				wd_rst_nxt = smc_pkg::SMC_WDOG_RST_RST;
				wd_cnt_nxt = smc_pkg::SMC_WDOG_CNT_RST;
				nmi_edge_sel_nxt = 1'b0;
			end
		end

		// read data captured in setup, stands through access
		if (rd) begin
			case (PADDR)
				smc_pkg::SMC_STANDBY_CTRL_ADDR:
					prdata_nxt = {24'h000000, sby_ctrl_r[7:6], 1'b0, smc_pkg::SMC_STANDBY_RSVD_ONES[4:0]};
				smc_pkg::SMC_WDOG_CTRL_ADDR: prdata_nxt = {24'h000000, wd_ctrl_r};
				smc_pkg::SMC_WDOG_RST_ADDR: prdata_nxt = {24'h000000, wd_rst_r};
				smc_pkg::SMC_WDOG_CNT_ADDR: prdata_nxt = {24'h000000, wd_cnt_r};
				smc_pkg::SMC_STATUS_ADDR: prdata_nxt = {24'h000000, 6'h00, 2'(state_r)};
				smc_pkg::SMC_CPU_CTRL_ADDR:
					prdata_nxt = {24'h000000, 6'h00, nmi_edge_sel_r, 1'b0};
				default: prdata_nxt = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state_r <= smc_pkg::SMC_RUN;
			sby_ctrl_r <= smc_pkg::SMC_STANDBY_CTRL_RST & 8'h1F;
			wd_ctrl_r <= smc_pkg::SMC_WDOG_CTRL_RST;
			wd_rst_r <= smc_pkg::SMC_WDOG_RST_RST;
			wd_cnt_r <= smc_pkg::SMC_WDOG_CNT_RST;
			wd_pre_r <= 11'h000;
			nmi_edge_sel_r <= 1'b0;
			nmi_prev_r <= 1'b0;
			rst_prev_r <= 1'b1;
			nmi_exc_r <= 1'b0;
			por_r <= 1'b0;
			mrst_r <= 1'b0;
			entry_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			state_r <= state_nxt;
			sby_ctrl_r <= sby_ctrl_nxt;
			wd_ctrl_r <= wd_ctrl_nxt;
			wd_rst_r <= wd_rst_nxt;
			wd_cnt_r <= wd_cnt_nxt;
			wd_pre_r <= wd_pre_nxt;
			nmi_edge_sel_r <= nmi_edge_sel_nxt;
			nmi_prev_r <= nmi_prev_nxt;
			rst_prev_r <= rst_prev_nxt;
			nmi_exc_r <= nmi_exc_nxt;
			por_r <= por_nxt;
			mrst_r <= mrst_nxt;
			entry_r <= entry_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// ----------------------------------------
	// power and init outputs
	// ----------------------------------------
	// cpu and ram simply stop clocking, so their contents are held
	assign pwr.cpu_stop = state_r != smc_pkg::SMC_RUN;
	assign pwr.clk_stop = state_r != smc_pkg::SMC_RUN;
	assign pwr.periph_stop = state_r != smc_pkg::SMC_RUN;
	assign pwr.wdog_clk_only = state_r == smc_pkg::SMC_SETTLE;
	assign pwr.ports_float = pwr.cpu_stop && sby_ctrl_r[smc_pkg::SMC_PORT_FLOAT_BIT];
	assign pwr.ports_hold = pwr.cpu_stop && !sby_ctrl_r[smc_pkg::SMC_PORT_FLOAT_BIT];
	assign init.dma_controller = entry_r;
	assign init.timer_pulse_unit = entry_r;
	assign init.adc = entry_r;
	assign init.serial_interface = entry_r;

	assign CPU_STOP = pwr.cpu_stop;
	assign SYS_CLK_STOP = pwr.clk_stop;
	assign PERIPH_STOP = pwr.periph_stop;
	assign WDOG_CLK_ONLY = pwr.wdog_clk_only;
	assign PORTS_FLOAT = pwr.ports_float;
	assign PORTS_HOLD = pwr.ports_hold;
	assign DMA_INIT = init.dma_controller;
	assign TPU_INIT = init.timer_pulse_unit;
	assign ADC_INIT = init.adc;
	assign SERIAL_INIT = init.serial_interface;
	assign NMI_EXCEPTION = nmi_exc_r;
	assign POWER_ON_RESET = por_r;
	assign MANUAL_RESET = mrst_r;
	assign NMI_EDGE_RISING = nmi_edge_sel_r && state_r == smc_pkg::SMC_RUN;
	assign PRDATA = prdata_r;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;

endmodule : smc_standby_ctrl

// ### hdl/smc_pkg.sv
// package for the standby mode controller: register map, fields, reset values, states
// assumes a 32-bit APB slave on a single 250 MHz clock
package smc_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] SMC_STANDBY_CTRL_ADDR = 8'h00;
	localparam logic [7:0] SMC_WDOG_CTRL_ADDR = 8'h04;
	localparam logic [7:0] SMC_WDOG_RST_ADDR = 8'h08;
	localparam logic [7:0] SMC_WDOG_CNT_ADDR = 8'h0C;
	localparam logic [7:0] SMC_STATUS_ADDR = 8'h10;
	localparam logic [7:0] SMC_CPU_CTRL_ADDR = 8'h14;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SMC_STANDBY_SELECT_BIT = 7;
	localparam int SMC_PORT_FLOAT_BIT = 6;
	localparam int SMC_WDOG_OVF_BIT = 7;
	localparam int SMC_WDOG_MODE_BIT = 6;
	localparam int SMC_WDOG_EN_BIT = 5;
	localparam int SMC_HALT_BIT = 0;
	localparam int SMC_NMI_EDGE_BIT = 1;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] SMC_STANDBY_CTRL_RST = 8'h1F;
	localparam logic [7:0] SMC_STANDBY_RSVD_ONES = 8'h1F;
	localparam logic [7:0] SMC_WDOG_CTRL_RST = 8'h18;
	localparam logic [7:0] SMC_WDOG_RST_RST = 8'h1F;
	localparam logic [7:0] SMC_WDOG_CNT_RST = 8'h00;

	// ----------------------------------------
	// states and carriers
	// ----------------------------------------
	typedef enum logic [1:0] {SMC_RUN, SMC_STANDBY, SMC_SETTLE} smc_state_t;

	typedef struct packed {
		logic cpu_stop;
		logic clk_stop;
		logic periph_stop;
		logic wdog_clk_only;
		logic ports_float;
		logic ports_hold;
	} smc_power_t;

	typedef struct packed {
		logic dma_controller;
		logic timer_pulse_unit;
		logic adc;
		logic serial_interface;
	} smc_init_t;

endpackage : smc_pkg

// ### tb/smc_standby_asserts.sv
// port checker for the standby mode controller
// assumes one SYS_CLK domain and RST async active high
`timescale 1ns/1ps
module smc_standby_asserts (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic HALT_EXEC,
	input wire logic NMI_PIN,
	input wire logic RESET_PIN_N,
	input wire logic CPU_STOP,
	input wire logic SYS_CLK_STOP,
	input wire logic PERIPH_STOP,
	input wire logic WDOG_CLK_ONLY,
	input wire logic PORTS_FLOAT,
	input wire logic PORTS_HOLD,
	input wire logic DMA_INIT,
	input wire logic TPU_INIT,
	input wire logic ADC_INIT,
	input wire logic SERIAL_INIT,
	input wire logic NMI_EXCEPTION,
	input wire logic POWER_ON_RESET,
	input wire logic MANUAL_RESET,
	input wire logic NMI_EDGE_RISING
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_entry; $rose(CPU_STOP) |-> $past(HALT_EXEC); endproperty
	a_entry: assert property (p_entry) else $error("stop without halt");
	property p_stop_all; CPU_STOP == SYS_CLK_STOP && CPU_STOP == PERIPH_STOP; endproperty
	a_stop_all: assert property (p_stop_all) else $error("stop outputs differ");
	property p_init_on; $rose(CPU_STOP) |-> DMA_INIT && TPU_INIT && ADC_INIT && SERIAL_INIT;
	endproperty
	a_init_on: assert property (p_init_on) else $error("init missing");
	property p_init_only; DMA_INIT || TPU_INIT || ADC_INIT || SERIAL_INIT |-> $rose(CPU_STOP);
	endproperty
	a_init_only: assert property (p_init_only) else $error("stray init");
	property p_ports; (PORTS_FLOAT || PORTS_HOLD) == CPU_STOP && !(PORTS_FLOAT && PORTS_HOLD);
	endproperty
	a_ports: assert property (p_ports) else $error("port state wrong");
	property p_ports_kept; CPU_STOP && $past(CPU_STOP) |-> $stable(PORTS_FLOAT); endproperty
	a_ports_kept: assert property (p_ports_kept) else $error("port choice moved");
	property p_settle; WDOG_CLK_ONLY |-> CPU_STOP; endproperty
	a_settle: assert property (p_settle) else $error("settle outside standby");
	property p_wake; CPU_STOP && !WDOG_CLK_ONLY && RESET_PIN_N && $fell(NMI_PIN)
		|-> ##[1:3] WDOG_CLK_ONLY; endproperty
	a_wake: assert property (p_wake) else $error("no settle after fall");
	property p_rise_ign; CPU_STOP && !WDOG_CLK_ONLY && $rose(NMI_PIN) |-> !WDOG_CLK_ONLY [*4];
	endproperty
	a_rise_ign: assert property (p_rise_ign) else $error("rising edge woke");
	property p_edge; CPU_STOP |-> !NMI_EDGE_RISING; endproperty
	a_edge: assert property (p_edge) else $error("edge not falling");
	property p_exit; $fell(CPU_STOP) |-> NMI_EXCEPTION || POWER_ON_RESET || MANUAL_RESET;
	endproperty
	a_exit: assert property (p_exit) else $error("exit without cause");
	property p_exc; NMI_EXCEPTION |-> $past(WDOG_CLK_ONLY) && !CPU_STOP; endproperty
	a_exc: assert property (p_exc) else $error("exception without settle");
	// the kind follows the nmi level at the pin fall, not a later level
	property p_kind; $fell(RESET_PIN_N) |-> ##1
		(POWER_ON_RESET == $past(NMI_PIN) && MANUAL_RESET == !$past(NMI_PIN));
	endproperty
	a_kind: assert property (p_kind) else $error("wrong reset kind");
	c_entry: cover property ($rose(CPU_STOP));
	c_nmi: cover property (NMI_EXCEPTION);
	c_por: cover property (POWER_ON_RESET);
	c_man: cover property (MANUAL_RESET);
endmodule : smc_standby_asserts
bind smc_standby_ctrl smc_standby_asserts chk_u (
	.SYS_CLK(SYS_CLK), .RST(RST), .HALT_EXEC(HALT_EXEC), .NMI_PIN(NMI_PIN),
	.RESET_PIN_N(RESET_PIN_N), .CPU_STOP(CPU_STOP), .SYS_CLK_STOP(SYS_CLK_STOP),
	.PERIPH_STOP(PERIPH_STOP), .WDOG_CLK_ONLY(WDOG_CLK_ONLY), .PORTS_FLOAT(PORTS_FLOAT),
	.PORTS_HOLD(PORTS_HOLD), .DMA_INIT(DMA_INIT), .TPU_INIT(TPU_INIT), .ADC_INIT(ADC_INIT),
	.SERIAL_INIT(SERIAL_INIT), .NMI_EXCEPTION(NMI_EXCEPTION),
	.POWER_ON_RESET(POWER_ON_RESET), .MANUAL_RESET(MANUAL_RESET),
	.NMI_EDGE_RISING(NMI_EDGE_RISING)
);

// ### tb/smc_pin_model.sv
// cpu halt and nmi/reset pin driver model
// assumes calls from the SYS_CLK domain
`timescale 1ns/1ps
module smc_pin_model (
	input wire logic clk,
	output logic halt,
	output logic nmi,
	output logic rst_pin_n
);
	initial begin
		halt = 1'b0;
		nmi = 1'b1;
		rst_pin_n = 1'b1;
	end
	// software picks cks so overflow outlasts oscillator settling
	task automatic do_halt();
		@(posedge clk) halt <= 1'b1;
		@(posedge clk) halt <= 1'b0;
	endtask : do_halt
	// level holds until told: high at entry for falling exit
	task automatic set_nmi(input logic v);
		@(posedge clk) nmi <= v;
	endtask : set_nmi
	task automatic set_rst(input logic v);
		@(posedge clk) rst_pin_n <= v;
	endtask : set_rst
endmodule : smc_pin_model

// ### tb/smc_standby_ctrl_tb.sv
// self-checking bench for the standby mode controller
// assumes the pin model drives halt, nmi and reset pin
`timescale 1ns/1ps
module smc_standby_ctrl_tb;
	logic SYS_CLK = 1'b0;
	logic RST;
	logic PSEL, PENABLE, PWRITE, err;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic PREADY, PSLVERR, CPU_STOP, SYS_CLK_STOP, PERIPH_STOP, WDOG_CLK_ONLY, PORTS_FLOAT;
	logic PORTS_HOLD, DMA_INIT, TPU_INIT, ADC_INIT, SERIAL_INIT, NMI_EXCEPTION;
	logic POWER_ON_RESET, MANUAL_RESET, NMI_EDGE_RISING;
	wire HALT_EXEC, NMI_PIN, RESET_PIN_N;
	wire [2:0] ev = {MANUAL_RESET, POWER_ON_RESET, NMI_EXCEPTION};
	int bad_count = 0;
	int checked = 0;
	always #2 SYS_CLK = ~SYS_CLK;
	smc_standby_ctrl dut_u (
		.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .HALT_EXEC(HALT_EXEC), .NMI_PIN(NMI_PIN),
		.RESET_PIN_N(RESET_PIN_N), .CPU_STOP(CPU_STOP), .SYS_CLK_STOP(SYS_CLK_STOP),
		.PERIPH_STOP(PERIPH_STOP), .WDOG_CLK_ONLY(WDOG_CLK_ONLY),
		.PORTS_FLOAT(PORTS_FLOAT), .PORTS_HOLD(PORTS_HOLD), .DMA_INIT(DMA_INIT),
		.TPU_INIT(TPU_INIT), .ADC_INIT(ADC_INIT), .SERIAL_INIT(SERIAL_INIT),
		.NMI_EXCEPTION(NMI_EXCEPTION), .POWER_ON_RESET(POWER_ON_RESET),
		.MANUAL_RESET(MANUAL_RESET), .NMI_EDGE_RISING(NMI_EDGE_RISING)
	);
	smc_pin_model pm_u (.clk(SYS_CLK), .halt(HALT_EXEC), .nmi(NMI_PIN), .rst_pin_n(RESET_PIN_N));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK) PENABLE <= 1'b1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
		chk("slverr", 32'h0, {31'h0, err});
	endtask : rdchk
	// a pulse is seen at the edge that samples it; exit drops the stops with it
	task automatic wait_ev(input int k, input string what);
		int n;
		n = 0;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (ev[k] !== 1'b1 && n < 600);
		chk(what, 32'h1, {31'h0, ev[k]});
		chk("run again", 32'h0, {30'h0, CPU_STOP, WDOG_CLK_ONLY});
	endtask : wait_ev
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdchk(8'h00, 32'h1F, "standby ctrl");
		rdchk(8'h04, 32'h18, "wdog ctrl");
		rdchk(8'h20, 32'h0, "unmapped");
		apb(1'b1, 8'h04, 32'h20);
		apb(1'b1, 8'h00, 32'hC0);
		rdchk(8'h00, 32'h1F, "select refused");
	endtask : t_regs
	task automatic t_nmi_exit();
		apb(1'b1, 8'h04, 32'h43);
		apb(1'b1, 8'h0C, 32'hFE);
		apb(1'b1, 8'h14, 32'h02);
		apb(1'b1, 8'h00, 32'hC0);
		chk("edge rising", 32'h1, {31'h0, NMI_EDGE_RISING});
		pm_u.set_nmi(1'b0);
		pm_u.do_halt();
		#1;
		chk("init", 32'hF, {28'h0, DMA_INIT, TPU_INIT, ADC_INIT, SERIAL_INIT});
		chk("stops", 32'h7, {29'h0, CPU_STOP, SYS_CLK_STOP, PERIPH_STOP});
		chk("float", 32'h2, {30'h0, PORTS_FLOAT, PORTS_HOLD});
		chk("edge forced", 32'h0, {31'h0, NMI_EDGE_RISING});
		rdchk(8'h04, 32'h1B, "wdog ctrl init");
		rdchk(8'h08, 32'h1F, "wdog rst init");
		rdchk(8'h0C, 32'hFE, "count kept");
		pm_u.set_nmi(1'b1);
		repeat (8) @(posedge SYS_CLK);
		chk("rise ignored", 32'h2, {30'h0, CPU_STOP, WDOG_CLK_ONLY});
		pm_u.set_nmi(1'b0);
		// edge seen one clock after the pin falls, settle shows the clock after that
		repeat (2) @(posedge SYS_CLK);
		chk("settle", 32'h3, {30'h0, CPU_STOP, WDOG_CLK_ONLY});
		rdchk(8'h10, 32'h2, "status settle");
		wait_ev(0, "nmi exit");
		rdchk(8'h04, 32'h9B, "overflow flag");
		rdchk(8'h00, 32'hDF, "standby kept");
		chk("edge kept", 32'h1, {31'h0, NMI_EDGE_RISING});
	endtask : t_nmi_exit
	task automatic t_resets();
		pm_u.set_nmi(1'b1);
		apb(1'b1, 8'h00, 32'h80);
		pm_u.do_halt();
		#1;
		chk("hold", 32'h1, {30'h0, PORTS_FLOAT, PORTS_HOLD});
		pm_u.set_rst(1'b0);
		wait_ev(1, "power-on reset");
		pm_u.set_rst(1'b1);
		rdchk(8'h00, 32'h1F, "restored");
		rdchk(8'h04, 32'h18, "wdog restored");
		pm_u.set_nmi(1'b0);
		apb(1'b1, 8'h00, 32'h80);
		pm_u.do_halt();
		pm_u.set_rst(1'b0);
		wait_ev(2, "manual reset");
		pm_u.set_rst(1'b1);
		rdchk(8'h00, 32'h9F, "manual kept");
	endtask : t_resets
	task automatic report_and_stop();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		RST <= 1'b1;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		PWRITE <= 1'b0;
		PADDR <= 8'h00;
		PWDATA <= 32'h00000000;
		repeat (10) @(posedge SYS_CLK);
		RST <= 1'b0;
		t_regs();
		t_nmi_exit();
		t_resets();
		report_and_stop();
	end
	initial begin
		#20000;
		bad_count++;
		report_and_stop();
	end
endmodule : smc_standby_ctrl_tb
